// ### design/core_state_pkg.sv
package core_state_pkg;

  localparam logic [5:0]  IO_SP_LOW     = 6'h3D;
  localparam logic [5:0]  IO_SP_HIGH    = 6'h3E;
  localparam logic [5:0]  IO_STATUS     = 6'h3F;
  localparam logic [7:0]  IO_UNMAPPED   = 8'h00;

  localparam int          ST_I          = 7;
  localparam int          ST_T          = 6;
  localparam int          ST_H          = 5;
  localparam int          ST_S          = 4;
  localparam int          ST_V          = 3;
  localparam int          ST_N          = 2;
  localparam int          ST_Z          = 1;
  localparam int          ST_C          = 0;

  localparam int          MSK_H         = 4;
  localparam int          MSK_V         = 3;
  localparam int          MSK_N         = 2;
  localparam int          MSK_Z         = 1;
  localparam int          MSK_C         = 0;

  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [15:0] SP_RESET      = 16'h0000;
  localparam logic [15:0] ADDR_RESET    = 16'h0000;

  localparam int          NUM_REGS      = 32;
  localparam logic [4:0]  PTR_X_LOW     = 5'h1A;
  localparam logic [4:0]  PTR_Y_LOW     = 5'h1C;
  localparam logic [4:0]  PTR_Z_LOW     = 5'h1E;
  localparam logic [15:0] REG_SPACE_TOP = 16'h001F;
  localparam logic [15:0] STEP_ONE      = 16'h0001;

  typedef enum logic [1:0] {
    PTR_X = 2'b00,
    PTR_Y = 2'b01,
    PTR_Z = 2'b10
  } ptr_sel_t;

  typedef enum logic [1:0] {
    PM_PLAIN   = 2'b00,
    PM_DISP    = 2'b01,
    PM_POSTINC = 2'b10,
    PM_PREDEC  = 2'b11
  } ptr_mode_t;

  typedef enum logic [2:0] {
    SP_HOLD  = 3'b000,
    SP_PUSH1 = 3'b001,
    SP_POP1  = 3'b010,
    SP_PUSH2 = 3'b011,
    SP_POP2  = 3'b100
  } sp_op_t;

  typedef enum logic [1:0] {
    RF_1R_W8    = 2'b00,
    RF_2R_W8    = 2'b01,
    RF_2R_W16   = 2'b10,
    RF_1R16_W16 = 2'b11
  } rf_scheme_t;

  typedef struct packed {
    logic       upd;
    logic [4:0] mask;
    logic       h;
    logic       v;
    logic       n;
    logic       z;
    logic       c;
  } alu_flags_t;

  typedef struct packed {
    logic       sei;
    logic       cli;
    logic       irq_accept;
    logic       irq_return;
    logic       bit_store;
    logic       store_bit;
    logic       sw_wr;
    logic [7:0] sw_data;
  } status_ctrl_t;

  typedef struct packed {
    rf_scheme_t scheme;
    logic [4:0] addr_a;
    logic [4:0] addr_b;
    logic [4:0] addr_w;
    logic       wr;
    logic [15:0] wdata;
    logic       bit_load;
    logic [2:0] bit_idx;
  } rf_req_t;

  typedef struct packed {
    logic      valid;
    ptr_sel_t  sel;
    ptr_mode_t mode;
    logic [5:0] disp;
  } ptr_req_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ds_req_t;

endpackage

// ### design/status_flags.sv
`timescale 1ns/100ps
module status_flags
  import core_state_pkg::*;
(
  input  wire logic         clock_in,
  input  wire logic         rst_in,
  input  wire alu_flags_t   alu_in,
  input  wire status_ctrl_t ctrl_in,
  output logic [7:0]        status_out
);

  logic [7:0] status_q;

  // sign bit always derived from stored n and v
  always_comb
  begin
    status_out       = status_q;
    status_out[ST_S] = status_q[ST_N] ^ status_q[ST_V];
  end

  // no save or restore on irq entry or return
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      status_q <= STATUS_RESET;
    else
    begin
      if (ctrl_in.sw_wr)
        status_q <= ctrl_in.sw_data;
      if (alu_in.upd)
      begin
        if (alu_in.mask[MSK_H])
          status_q[ST_H] <= alu_in.h;
        if (alu_in.mask[MSK_V])
          status_q[ST_V] <= alu_in.v;
        if (alu_in.mask[MSK_N])
          status_q[ST_N] <= alu_in.n;
        if (alu_in.mask[MSK_Z])
          status_q[ST_Z] <= alu_in.z;
        if (alu_in.mask[MSK_C])
          status_q[ST_C] <= alu_in.c;
      end
      if (ctrl_in.bit_store)
        status_q[ST_T] <= ctrl_in.store_bit;
      if (ctrl_in.sei || ctrl_in.irq_return)
        status_q[ST_I] <= 1'b1;
      if (ctrl_in.cli || ctrl_in.irq_accept)
        status_q[ST_I] <= 1'b0;
    end
  end

  AST_ACCEPT_CLEARS_I: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ctrl_in.irq_accept |=> !status_out[ST_I])
    else $error("enable still set after irq accept");

  AST_RETURN_SETS_I: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ctrl_in.irq_return && !ctrl_in.irq_accept && !ctrl_in.cli
    |=> status_out[ST_I])
    else $error("enable not set after irq return");

  AST_NO_SAVE: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (ctrl_in.irq_accept || ctrl_in.irq_return) && !alu_in.upd
    && !ctrl_in.sw_wr && !ctrl_in.bit_store
    |=> status_out[6:0] == $past(status_out[6:0]))
    else $error("status changed by irq entry or return");

  AST_CARRY: assert property (
    @(posedge clock_in) disable iff (rst_in)
    alu_in.upd && alu_in.mask[MSK_C]
    |=> status_out[ST_C] == $past(alu_in.c))
    else $error("carry flag not taken from alu");

  AST_SIGN: assert property (
    @(posedge clock_in) disable iff (rst_in)
    alu_in.upd && alu_in.mask[MSK_N] && alu_in.mask[MSK_V]
    |=> status_out[ST_S] == ($past(alu_in.n) ^ $past(alu_in.v)))
    else $error("sign bit not n xor v");

  AST_T_STORE: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ctrl_in.bit_store |=> status_out[ST_T] == $past(ctrl_in.store_bit))
    else $error("transfer bit not stored");

endmodule // status_flags

// ### design/cpu_status_regfile_stack.sv
// What this block does
// - arithmetic flags updated at end of every alu operation
// - status never saved on irq entry nor restored on return
// - global enable bit 7 gates every interrupt
// - enable cleared on irq accept, set on irq return
// - set and clear instructions directly write the global enable
// - bit 6 is a transfer bit for bit store and bit load
// - bit 5 holds the low nibble carry
// - bit 4 always equals negative xor overflow
// - bit 3 holds two's complement overflow
// - bit 2 set on negative result, else cleared
// - bit 1 set on zero result, else cleared
// - bit 0 holds the carry
// - four read and write-back port schemes of 8 and 16 bits
// - working registers also at data addresses 0x00 to 0x1F
// - top six registers form three pointers, low byte even
// - pointers allow displacement, post increment and pre decrement
// - stack pointer marks top of downward growing stack
// - stack pointer minus one per push, plus one per pop
// - stack pointer moves by two for return addresses
// - stack pointer is two byte registers at 0x3E and 0x3D, reset 0
// - one instruction runs after irq return before next irq
`timescale 1ns/100ps
module cpu_status_regfile_stack
  import core_state_pkg::*;
(
  input  wire logic         clock_in,
  input  wire logic         rst_in,
  input  wire alu_flags_t   alu_in,
  input  wire status_ctrl_t ctrl_in,
  input  wire rf_req_t      rf_in,
  input  wire ptr_req_t     ptr_in,
  input  wire sp_op_t       sp_op_in,
  input  wire io_req_t      io_in,
  input  wire ds_req_t      ds_in,
  input  wire logic         irq_pending_in,
  input  wire logic         insn_done_in,
  output logic [7:0]        status_out,
  output logic [7:0]        rd_a_out,
  output logic [7:0]        rd_b_out,
  output logic [15:0]       rd_word_out,
  output logic [15:0]       ptr_addr_out,
  output logic [15:0]       stack_addr_out,
  output logic [15:0]       stack_ptr_out,
  output logic [7:0]        io_rdata_out,
  output logic              io_hit_out,
  output logic [7:0]        ds_rdata_out,
  output logic              ds_hit_out,
  output logic              irq_take_out
);

  logic [7:0]  regs_q [NUM_REGS];
  logic [15:0] sp_q;
  logic [15:0] sp_d;
  logic        hold_q;
  logic [4:0]  ptr_low;
  logic [15:0] ptr_base;
  logic [15:0] ptr_eff;
  logic [15:0] ptr_new;
  logic        ptr_wb;
  logic        ds_reg_hit;
  status_ctrl_t ctrl_mux;

  function automatic logic [4:0] pair_low(input logic [4:0] a);
    pair_low = {a[4:1], 1'b0};
  endfunction

  function automatic logic [4:0] pair_high(input logic [4:0] a);
    pair_high = {a[4:1], 1'b1};
  endfunction

  function automatic logic [4:0] ptr_low_of(input ptr_sel_t s);
    case (s)
      PTR_X:   ptr_low_of = PTR_X_LOW;
      PTR_Y:   ptr_low_of = PTR_Y_LOW;
      PTR_Z:   ptr_low_of = PTR_Z_LOW;
      default: ptr_low_of = PTR_Z_LOW;
    endcase
  endfunction

  // software writes to status go through the io port
  always_comb
  begin
    ctrl_mux         = ctrl_in;
    ctrl_mux.sw_wr   = io_in.wr && (io_in.addr == IO_STATUS);
    ctrl_mux.sw_data = io_in.wdata;
  end

  status_flags status_flags_inst (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .alu_in     (alu_in),
    .ctrl_in    (ctrl_mux),
    .status_out (status_out)
  );

  // irq gate: global enable, immediate clear, one instruction after return
  assign irq_take_out = irq_pending_in && status_out[ST_I]
                        && !ctrl_in.cli && !hold_q;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      hold_q <= 1'b0;
    else if (ctrl_in.irq_return || (ctrl_in.sei && !status_out[ST_I]))
      hold_q <= 1'b1;
    else if (insn_done_in)
      hold_q <= 1'b0;
  end

  // pointer address arithmetic
  always_comb
  begin
    ptr_low  = ptr_low_of(ptr_in.sel);
    ptr_base = {regs_q[pair_high(ptr_low)], regs_q[ptr_low]};
    ptr_eff  = ptr_base;
    ptr_new  = ptr_base;
    ptr_wb   = 1'b0;
    case (ptr_in.mode)
      PM_PLAIN:   ptr_eff = ptr_base;
      PM_DISP:    ptr_eff = ptr_base + {10'h000, ptr_in.disp};
      PM_POSTINC:
      begin
        ptr_new = ptr_base + STEP_ONE;
        ptr_wb  = ptr_in.valid;
      end
      PM_PREDEC:
      begin
        ptr_eff = ptr_base - STEP_ONE;
        ptr_new = ptr_base - STEP_ONE;
        ptr_wb  = ptr_in.valid;
      end
      default:    ptr_eff = ptr_base;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      ptr_addr_out <= ADDR_RESET;
    else if (ptr_in.valid)
      ptr_addr_out <= ptr_eff;
  end

  assign ds_reg_hit = ds_in.addr <= REG_SPACE_TOP;

  // register file write: alu port over data space over pointer update
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs_q[i] <= REG_RESET;
    end
    else
    begin
      if (ptr_wb)
      begin
        regs_q[ptr_low]            <= ptr_new[7:0];
        regs_q[pair_high(ptr_low)] <= ptr_new[15:8];
      end
      if (ds_in.wr && ds_reg_hit)
        regs_q[ds_in.addr[4:0]] <= ds_in.wdata;
      if (rf_in.bit_load)
        regs_q[rf_in.addr_w][rf_in.bit_idx] <= status_out[ST_T];
      else if (rf_in.wr)
      begin
        case (rf_in.scheme)
          RF_1R_W8, RF_2R_W8:
            regs_q[rf_in.addr_w] <= rf_in.wdata[7:0];
          RF_2R_W16, RF_1R16_W16:
          begin
            regs_q[pair_low(rf_in.addr_w)]  <= rf_in.wdata[7:0];
            regs_q[pair_high(rf_in.addr_w)] <= rf_in.wdata[15:8];
          end
          default:
            regs_q[rf_in.addr_w] <= rf_in.wdata[7:0];
        endcase
      end
    end
  end

  // operand reads, registered
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_a_out    <= REG_RESET;
      rd_b_out    <= REG_RESET;
      rd_word_out <= ADDR_RESET;
    end
    else
    begin
      rd_a_out    <= regs_q[rf_in.addr_a];
      rd_b_out    <= (rf_in.scheme == RF_2R_W8 || rf_in.scheme == RF_2R_W16)
                     ? regs_q[rf_in.addr_b] : REG_RESET;
      rd_word_out <= (rf_in.scheme == RF_1R16_W16)
                     ? {regs_q[pair_high(rf_in.addr_a)],
                        regs_q[pair_low(rf_in.addr_a)]}
                     : ADDR_RESET;
    end
  end

  // data space read of the register file
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ds_rdata_out <= REG_RESET;
      ds_hit_out   <= 1'b0;
    end
    else
    begin
      ds_hit_out   <= (ds_in.rd || ds_in.wr) && ds_reg_hit;
      ds_rdata_out <= (ds_in.rd && ds_reg_hit)
                      ? regs_q[ds_in.addr[4:0]] : REG_RESET;
    end
  end

  // stack pointer next value; a software write wins over a stack op
  always_comb
  begin
    case (sp_op_in)
      SP_HOLD:  sp_d = sp_q;
      SP_PUSH1: sp_d = sp_q - 16'h0001;
      SP_POP1:  sp_d = sp_q + 16'h0001;
      SP_PUSH2: sp_d = sp_q - 16'h0002;
      SP_POP2:  sp_d = sp_q + 16'h0002;
      default:  sp_d = sp_q;
    endcase
    if (io_in.wr && io_in.addr == IO_SP_LOW)
      sp_d = {sp_q[15:8], io_in.wdata};
    if (io_in.wr && io_in.addr == IO_SP_HIGH)
      sp_d = {io_in.wdata, sp_q[7:0]};
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      sp_q <= SP_RESET;
    else
      sp_q <= sp_d;
  end

  assign stack_ptr_out = sp_q;

  // memory address of the stack access: push at top, pop above it
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      stack_addr_out <= ADDR_RESET;
    else if (sp_op_in == SP_PUSH1 || sp_op_in == SP_PUSH2)
      stack_addr_out <= sp_q;
    else if (sp_op_in == SP_POP1 || sp_op_in == SP_POP2)
      stack_addr_out <= sp_q + STEP_ONE;
  end

  // io register reads
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      io_rdata_out <= IO_UNMAPPED;
      io_hit_out   <= 1'b0;
    end
    else
    begin
      io_hit_out <= (io_in.rd || io_in.wr) && (io_in.addr == IO_SP_LOW
                    || io_in.addr == IO_SP_HIGH || io_in.addr == IO_STATUS);
      if (!io_in.rd)
        io_rdata_out <= IO_UNMAPPED;
      else
      begin
        case (io_in.addr)
          IO_SP_LOW:  io_rdata_out <= sp_q[7:0];
          IO_SP_HIGH: io_rdata_out <= sp_q[15:8];
          IO_STATUS:  io_rdata_out <= status_out;
          default:    io_rdata_out <= IO_UNMAPPED;
        endcase
      end
    end
  end

  AST_GIE_GATES: assert property (
    @(posedge clock_in) disable iff (rst_in)
    !status_out[ST_I] |-> !irq_take_out)
    else $error("irq taken with global enable clear");

  AST_ONE_AFTER_RETURN: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ctrl_in.irq_return |=> !irq_take_out)
    else $error("irq taken right after irq return");

  AST_PUSH_ONE: assert property (
    @(posedge clock_in) disable iff (rst_in)
    sp_op_in == SP_PUSH1 && !io_in.wr
    |=> sp_q == $past(sp_q) - 16'h0001)
    else $error("push did not decrement by one");

  AST_POP_TWO: assert property (
    @(posedge clock_in) disable iff (rst_in)
    sp_op_in == SP_POP2 && !io_in.wr
    |=> sp_q == $past(sp_q) + 16'h0002 ##1 1'b1)
    else $error("return did not increment by two");

  AST_PUSH_ADDR: assert property (
    @(posedge clock_in) disable iff (rst_in)
    sp_op_in == SP_PUSH2 && !io_in.wr
    |=> stack_addr_out == sp_q + 16'h0002)
    else $error("push address not old top");

  AST_POSTINC: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ptr_in.valid && ptr_in.mode == PM_POSTINC && ptr_in.sel == PTR_X
    && !rf_in.wr && !rf_in.bit_load && !ds_in.wr
    |=> {regs_q[5'h1B], regs_q[PTR_X_LOW]} == ptr_addr_out + 16'h0001)
    else $error("pointer not incremented");

  AST_SPH_READ: assert property (
    @(posedge clock_in) disable iff (rst_in)
    io_in.rd && io_in.addr == IO_SP_HIGH |=> io_rdata_out == $past(sp_q[15:8]))
    else $error("stack high byte read wrong");

endmodule // cpu_status_regfile_stack

// ### verification/core_seq_model.sv
`timescale 1ns/100ps
module core_seq_model
  import core_state_pkg::*;
(
  input  wire logic         auto_in,
  input  wire logic         take_in,
  input  wire status_ctrl_t ctrl_in,
  input  wire sp_op_t       sp_op_in,
  output status_ctrl_t      ctrl_out,
  output sp_op_t            sp_op_out
);
  // accept a taken interrupt, push the return address
  always_comb
  begin
    ctrl_out  = ctrl_in;
    sp_op_out = sp_op_in;
    if (auto_in && take_in)
    begin
      ctrl_out.irq_accept = 1'b1;
      sp_op_out           = SP_PUSH2;
    end
  end
endmodule // core_seq_model

// ### verification/cpu_status_regfile_stack_test.sv
`timescale 1ns/100ps
module cpu_status_regfile_stack_test
  import core_state_pkg::*;
;
  logic         clock_in, rst_in, pend, done, auto;
  alu_flags_t   alu;
  status_ctrl_t tctrl, ctrl;
  rf_req_t      rf;
  ptr_req_t     ptr;
  sp_op_t       tsp, sp;
  io_req_t      io;
  ds_req_t      ds;
  logic [7:0]   st, rda, rdb, iod, dsd;
  logic [15:0]  rdw, pa, sa, spv;
  logic         ioh, dsh, take;
  int           miscompares, checks_done;

  cpu_status_regfile_stack cpu_status_regfile_stack_inst (
    .clock_in(clock_in), .rst_in(rst_in), .alu_in(alu), .ctrl_in(ctrl),
    .rf_in(rf), .ptr_in(ptr), .sp_op_in(sp), .io_in(io), .ds_in(ds),
    .irq_pending_in(pend), .insn_done_in(done), .status_out(st),
    .rd_a_out(rda), .rd_b_out(rdb), .rd_word_out(rdw),
    .ptr_addr_out(pa), .stack_addr_out(sa), .stack_ptr_out(spv),
    .io_rdata_out(iod), .io_hit_out(ioh), .ds_rdata_out(dsd),
    .ds_hit_out(dsh), .irq_take_out(take));

  core_seq_model core_seq_model_inst (
    .auto_in(auto), .take_in(take), .ctrl_in(tctrl), .sp_op_in(tsp),
    .ctrl_out(ctrl), .sp_op_out(sp));

  always #20 clock_in = ~clock_in;

  task automatic step();
    @(negedge clock_in);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp)
    begin
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
      miscompares++;
    end
  endtask

  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    io = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    step();
    io.wr = 1'b0;
    step();
  endtask

  task automatic io_rd(input logic [5:0] a, input logic [7:0] e,
                       input logic h);
    io = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    step();
    io.rd = 1'b0;
    chk({8'h00, iod}, {8'h00, e}, "io read data");
    chk({15'h0000, ioh}, {15'h0000, h}, "io hit");
    step();
  endtask

  task automatic ds_rd(input logic [15:0] a, input logic [7:0] e,
                       input logic h);
    ds = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    step();
    ds.rd = 1'b0;
    chk({8'h00, dsd}, {8'h00, e}, "data space read");
    chk({15'h0000, dsh}, {15'h0000, h}, "data space hit");
    step();
  endtask

  task automatic test_reset();
    chk({8'h00, st}, 16'h0000, "status after reset");
    io_rd(IO_SP_LOW, 8'h00, 1'b1);
    io_rd(IO_SP_HIGH, 8'h00, 1'b1);
    io_rd(6'h00, 8'h00, 1'b0);
  endtask

  task automatic alu_op(input logic [4:0] m, input logic [4:0] f,
                        input logic [7:0] e);
    alu = {1'b1, m, f};
    step();
    alu.upd = 1'b0;
    chk({8'h00, st}, {8'h00, e}, "status after alu op");
    step();
  endtask

  task automatic test_flags();
    alu_op(5'h1F, 5'b10101, 8'h35);
    alu_op(5'h02, 5'b00010, 8'h37);
    alu_op(5'h08, 5'b01000, 8'h2F);
    io_rd(IO_STATUS, 8'h2F, 1'b1);
    tctrl.bit_store = 1'b1;
    tctrl.store_bit = 1'b1;
    step();
    tctrl.bit_store = 1'b0;
    chk({8'h00, st}, 16'h006F, "transfer bit");
    rf.bit_load = 1'b1;
    rf.addr_w = 5'h05;
    rf.bit_idx = 3'd3;
    step();
    rf.bit_load = 1'b0;
    ds_rd(16'h0005, 8'h08, 1'b1);
  endtask

  task automatic ptr_op(input ptr_sel_t s, input ptr_mode_t m,
                        input logic [5:0] d, input logic [15:0] e);
    ptr = '{valid: 1'b1, sel: s, mode: m, disp: d};
    step();
    ptr.valid = 1'b0;
    chk(pa, e, "pointer address");
    step();
  endtask

  task automatic test_regs();
    rf = '{scheme: RF_2R_W16, addr_a: PTR_X_LOW, addr_b: 5'h1B,
           addr_w: PTR_X_LOW, wr: 1'b1, wdata: 16'h1234,
           bit_load: 1'b0, bit_idx: 3'd0};
    step();
    rf.wr = 1'b0;
    ds_rd(16'h001A, 8'h34, 1'b1);
    ds_rd(REG_SPACE_TOP - 16'h0004, 8'h12, 1'b1);
    chk({8'h00, rdb}, 16'h0012, "second operand");
    rf.scheme = RF_1R16_W16;
    step();
    step();
    chk(rdw, 16'h1234, "word operand");
    ptr_op(PTR_X, PM_POSTINC, 6'h00, 16'h1234);
    ds_rd(16'h001A, 8'h35, 1'b1);
    ptr_op(PTR_X, PM_PREDEC, 6'h00, 16'h1234);
    ptr_op(PTR_X, PM_DISP, 6'h05, 16'h1239);
    ptr_op(PTR_Y, PM_PLAIN, 6'h00, 16'h0000);
    rf = '{scheme: RF_1R_W8, addr_a: 5'h02, addr_b: 5'h05,
           addr_w: 5'h02, wr: 1'b1, wdata: 16'hBEA5,
           bit_load: 1'b0, bit_idx: 3'd0};
    step();
    rf.wr = 1'b0;
    step();
    chk({8'h00, rda}, 16'h00A5, "first operand");
    chk({8'h00, rdb}, 16'h0000, "second operand unused");
    chk(rdw, 16'h0000, "word operand unused");
    ds_rd(16'h0003, 8'h00, 1'b1);
    rf.scheme = RF_2R_W8;
    step();
    chk({8'h00, rdb}, 16'h0008, "second operand 8 bit");
    ds = '{wr: 1'b1, rd: 1'b0, addr: 16'h0004, wdata: 8'h5A};
    step();
    ds.wr = 1'b0;
    step();
    ds_rd(16'h0004, 8'h5A, 1'b1);
    ds_rd(16'h0060, 8'h00, 1'b0);
  endtask

  task automatic sp_step(input sp_op_t o, input logic [15:0] es,
                         input logic [15:0] ea);
    tsp = o;
    step();
    tsp = SP_HOLD;
    chk(spv, es, "stack pointer");
    chk(sa, ea, "stack address");
    step();
  endtask

  task automatic test_stack();
    io_wr(IO_SP_HIGH, 8'h10);
    io_wr(IO_SP_LOW, 8'hFF);
    chk(spv, 16'h10FF, "stack pointer load");
    sp_step(SP_PUSH1, 16'h10FE, 16'h10FF);
    sp_step(SP_POP1, 16'h10FF, 16'h10FF);
    sp_step(SP_PUSH2, 16'h10FD, 16'h10FF);
    sp_step(SP_POP2, 16'h10FF, 16'h10FE);
    io_rd(IO_SP_HIGH, 8'h10, 1'b1);
    chk(spv & 16'h7FFF, 16'h10FF, "masked stack value");
  endtask

  task automatic test_irq();
    pend = 1'b1;
    step();
    chk({15'h0000, take}, 16'h0000, "take while disabled");
    auto = 1'b1;
    tctrl.sei = 1'b1;
    step();
    tctrl.sei = 1'b0;
    chk({8'h00, st}, 16'h00EF, "status after enable");
    chk({15'h0000, take}, 16'h0000, "take before insn");
    done = 1'b1;
    step();
    done = 1'b0;
    chk({15'h0000, take}, 16'h0001, "take when enabled");
    step();
    chk({8'h00, st}, 16'h006F, "status after accept");
    chk(spv, 16'h10FD, "stack after accept");
    tctrl.irq_return = 1'b1;
    tsp = SP_POP2;
    step();
    tctrl.irq_return = 1'b0;
    tsp = SP_HOLD;
    chk({8'h00, st}, 16'h00EF, "status after return");
    chk({15'h0000, take}, 16'h0000, "take right after return");
    auto = 1'b0;
    done = 1'b1;
    step();
    done = 1'b0;
    tctrl.cli = 1'b1;
    #1;
    chk({15'h0000, take}, 16'h0000, "take during disable");
    step();
    tctrl.cli = 1'b0;
    pend = 1'b0;
    chk({8'h00, st}, 16'h006F, "status after disable");
    io_wr(IO_STATUS, 8'h10);
    chk({8'h00, st}, 16'h0000, "sign bit write ignored");
  endtask

  task automatic summarize();
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #(40 * 3000);
    miscompares++;
    summarize();
  end

  initial
  begin
    clock_in = 1'b0;
    rst_in = 1'b1;
    {pend, done, auto} = 3'b000;
    alu = '0;
    tctrl = '0;
    rf = '0;
    ptr = '0;
    tsp = SP_HOLD;
    io = '0;
    ds = '0;
    miscompares = 0;
    checks_done = 0;
    repeat (16) @(posedge clock_in);
    step();
    rst_in = 1'b0;
    test_reset();
    test_flags();
    test_regs();
    test_stack();
    test_irq();
    summarize();
  end
endmodule // cpu_status_regfile_stack_test
